// File: nes_event_status.sv
// nes_event_status: low event status flags, mask and receive resource tracking
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/10ps
module nes_event_status (
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  reset,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // event sources
    input  wire nes_pkg::nes_tx_evt_t  txEvt,
    input  wire logic [31:0]           timerValue,
    input  wire nes_pkg::nes_tally_t   tallyValue,
    input  wire nes_pkg::nes_rx_evt_t  rxEvt,
    // receive control and transmit status
    output nes_pkg::nes_rx_ctl_t       rxCtl,
    output nes_pkg::nes_tx_cause_t     txDescStatus,
    // interrupt
    output logic                       irq
);
    import nes_pkg::*;

    nes_state_t           st;
    nes_state_t           st_nxt;
    logic [NUM_FLAGS-1:0] flags;
    logic [NUM_FLAGS-1:0] setEv;
    logic [NUM_FLAGS-1:0] clrMask;
    logic [2:0]           tallyWrap;
    logic                 setup;
    logic                 access;
    logic                 mapped;
    logic                 wrEn;
    logic                 wrStatus;
    logic                 wrCtl;
    logic                 more;
    logic                 rbeClear;
    logic                 cmdFetch;
    logic                 consume;
    logic                 wantFetch;
    logic                 rbeSet;
    logic [PTR_W-1:0]     rptrStep;
    logic [31:0]          readMux;

    // ---- apb decode ----
    assign setup    = psel & ~penable;
    assign access   = psel & penable;
    assign wrEn     = access & pwrite & mapped;
    assign wrStatus = wrEn & (paddr == OFS_STATUS);
    assign wrCtl    = wrEn & (paddr == OFS_RXCTL);
    // zero wait states: read data is captured in the setup cycle
    assign pready   = 1'b1;
    assign pslverr  = access & ~mapped;
    assign prdata   = st.prdata;

    always_comb begin
        mapped  = 1'b1;
        readMux = 32'h0000_0000;
        unique case (paddr)
            OFS_STATUS: readMux = {23'h000000, flags};
            OFS_MASK:   readMux = {23'h000000, st.mask};
            OFS_WPTR:   readMux = {16'h0000, st.wptr};
            OFS_RPTR:   readMux = {16'h0000, st.rptr};
            OFS_RXCTL:  readMux = {30'h00000000, st.fetchBusy, st.halted};
            OFS_TXST:   readMux = {28'h0000000, st.txStatus};
            default:    mapped  = 1'b0;
        endcase
    end

    // ---- event detection ----
    genvar i;
    generate
        for (i = 0; i < 3; i++) begin : g_tally
            assign tallyWrap[i] = (st.tallyPrev[i] == TALLY_MAX)
                                & (tallyValue[i] == TALLY_ZERO);
        end
    endgenerate

    assign rptrStep = st.rptr + RES_ENTRY_STEP;
    // the warning fires on fetching the final entry, one buffer ahead of starvation
    assign rbeSet   = rxEvt.fetchDone & st.fetchBusy & (rptrStep == st.wptr);

    always_comb begin
        setEv                  = '0;
        setEv[FLG_TX_ERR]      = txEvt.txDone & (|txEvt.cause);
        setEv[FLG_TIMER]       = (st.timerPrev == TIMER_ZERO)
                               & (timerValue == TIMER_ONES);
        setEv[FLG_DESC_EXH]    = rxEvt.listEndSeen;
        setEv[FLG_BUF_EXH]     = rbeSet;
        setEv[FLG_AREA]        = rxEvt.areaEndHit;
        setEv[FLG_TALLY0 +: 3] = tallyWrap;
        // transmit underrun is reported elsewhere, only receive overrun here
        setEv[FLG_RX_FIFO]     = rxEvt.fifoFull & ~rxEvt.busGranted;
    end

    assign clrMask = wrStatus ? pwdata[NUM_FLAGS-1:0] : '0;

    nes_sticky_bank #(
        .WIDTH (NUM_FLAGS)
    ) u_bank (
        .clock   (clock),
        .reset   (reset),
        .setEv   (setEv),
        .clrMask (clrMask),
        .flags   (flags)
    );

    // ---- receive resource fetch ----
    assign more      = st.wptr != st.rptr;
    assign rbeClear  = wrStatus & pwdata[FLG_BUF_EXH] & flags[FLG_BUF_EXH];
    assign cmdFetch  = wrCtl & pwdata[CTL_READ_RES];
    assign consume   = rxEvt.bufferDone | rxEvt.areaEndHit;
    // clearing the warning fetches only when entries were added (wptr differs from rptr)
    assign wantFetch = (consume & more & ~st.halted)
                     | cmdFetch
                     | (rbeClear & more);

    always_comb begin
        st_nxt            = st;
        st_nxt.fetchReq   = 1'b0;
        st_nxt.frameAbort = rxEvt.areaEndHit;
        st_nxt.timerPrev  = timerValue;
        st_nxt.tallyPrev  = tallyValue;
        st_nxt.irq        = |(flags & st.mask);
        if (setup) begin
            st_nxt.prdata = readMux;
        end
        if (txEvt.txDone) begin
            st_nxt.txStatus = txEvt.cause;
        end
        if (wrEn && paddr == OFS_MASK) begin
            st_nxt.mask = pwdata[NUM_FLAGS-1:0];
        end
        if (wrEn && paddr == OFS_WPTR) begin
            st_nxt.wptr = pwdata[PTR_W-1:0];
        end
        if (wrEn && paddr == OFS_RPTR) begin
            st_nxt.rptr = pwdata[PTR_W-1:0];
        end
        // last buffer used up with nothing left: stop taking frames
        if (consume && !more) begin
            st_nxt.halted = 1'b1;
        end
        // a request arriving during a fetch is dropped; one fetch at a time
        if (wantFetch && !st.fetchBusy) begin
            st_nxt.fetchReq    = 1'b1;
            st_nxt.fetchBusy   = 1'b1;
            st_nxt.resumeFetch = (rbeClear & more)
                               | (cmdFetch & ~flags[FLG_BUF_EXH]);
        end
        if (rxEvt.fetchDone && st.fetchBusy) begin
            st_nxt.rptr        = rptrStep;
            st_nxt.fetchBusy   = 1'b0;
            st_nxt.resumeFetch = 1'b0;
            if (st.resumeFetch) begin
                st_nxt.halted = 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            st <= STATE_RESET;
        end else begin
            st <= st_nxt;
        end
    end

    assign rxCtl.fetchReq   = st.fetchReq;
    assign rxCtl.frameAbort = st.frameAbort;
    assign rxCtl.rxEnable   = ~st.halted;
    assign txDescStatus     = st.txStatus;
    assign irq              = st.irq;

    // ---- assertions ----
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    property p_tx_err;
        txEvt.txDone && (|txEvt.cause)
        |=> flags[FLG_TX_ERR] && (txDescStatus == $past(txEvt.cause));
    endproperty
    a_p_tx_err: assert property (p_tx_err)
        else $error("tx error flag or cause not recorded");

    property p_timer;
        (st.timerPrev == TIMER_ZERO) && (timerValue == TIMER_ONES)
        |=> flags[FLG_TIMER];
    endproperty
    a_p_timer: assert property (p_timer)
        else $error("timer wrap did not set flag");

    property p_desc_exh;
        rxEvt.listEndSeen |=> flags[FLG_DESC_EXH];
    endproperty
    a_p_desc_exh: assert property (p_desc_exh)
        else $error("descriptor exhausted flag missing");

    property p_buf_exh;
        rxEvt.fetchDone && st.fetchBusy && (rptrStep == st.wptr)
        |=> flags[FLG_BUF_EXH] && (st.rptr == st.wptr);
    endproperty
    a_p_buf_exh: assert property (p_buf_exh)
        else $error("buffer exhausted flag missing at pointer match");

    property p_early;
        rbeSet && !st.halted && !consume |=> rxCtl.rxEnable;
    endproperty
    a_p_early: assert property (p_early)
        else $error("warning came only after reception stopped");

    property p_halt;
        !rxCtl.rxEnable && !(rxEvt.fetchDone && st.fetchBusy && st.resumeFetch)
        |=> !rxCtl.rxEnable;
    endproperty
    a_p_halt: assert property (p_halt)
        else $error("reception resumed without resources");

    property p_resume;
        rbeClear && more && !st.fetchBusy
        |=> rxCtl.fetchReq ##1 !rxCtl.fetchReq;
    endproperty
    a_p_resume: assert property (p_resume)
        else $error("clearing buffer flag did not fetch");

    property p_area;
        rxEvt.areaEndHit |=> flags[FLG_AREA] && rxCtl.frameAbort;
    endproperty
    a_p_area: assert property (p_area)
        else $error("area end did not flag and abort");

    property p_crc;
        tallyWrap[2] |=> flags[3];
    endproperty
    a_p_crc: assert property (p_crc)
        else $error("checksum tally wrap missed");

    property p_align;
        tallyWrap[1] |=> flags[2];
    endproperty
    a_p_align: assert property (p_align)
        else $error("alignment tally wrap missed");

    property p_missed;
        tallyWrap[0] |=> flags[1];
    endproperty
    a_p_missed: assert property (p_missed)
        else $error("missed frame tally wrap missed");

    property p_fifo;
        rxEvt.fifoFull && !rxEvt.busGranted |=> flags[FLG_RX_FIFO];
    endproperty
    a_p_fifo: assert property (p_fifo)
        else $error("fifo overrun not flagged");

    property p_w1c_zero;
        wrStatus && !pwdata[FLG_TX_ERR] && flags[FLG_TX_ERR]
        |=> flags[FLG_TX_ERR];
    endproperty
    a_p_w1c_zero: assert property (p_w1c_zero)
        else $error("writing zero cleared a flag");

    property p_mask;
        ((flags & st.mask) == '0) ##1 ((flags & st.mask) == '0) |=> !irq;
    endproperty
    a_p_mask: assert property (p_mask)
        else $error("interrupt raised with masked flags");
endmodule : nes_event_status

// File: nes_pkg.sv
// nes_pkg: constants and types for the low event status block
package nes_pkg;
    localparam int unsigned NUM_FLAGS = 9;
    localparam int unsigned APB_AW    = 8;
    localparam int unsigned PTR_W     = 16;

    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_MASK   = 8'h04;
    localparam logic [7:0] OFS_WPTR   = 8'h08;
    localparam logic [7:0] OFS_RPTR   = 8'h0C;
    localparam logic [7:0] OFS_RXCTL  = 8'h10;
    localparam logic [7:0] OFS_TXST   = 8'h14;

    localparam int unsigned FLG_RX_FIFO  = 0;
    localparam int unsigned FLG_TALLY0   = 1;
    localparam int unsigned FLG_AREA     = 4;
    localparam int unsigned FLG_BUF_EXH  = 5;
    localparam int unsigned FLG_DESC_EXH = 6;
    localparam int unsigned FLG_TIMER    = 7;
    localparam int unsigned FLG_TX_ERR   = 8;
    localparam int unsigned CTL_READ_RES = 0;

    localparam logic [8:0]       FLAGS_RESET    = 9'h000;
    localparam logic [8:0]       MASK_RESET     = 9'h000;
    localparam logic [PTR_W-1:0] PTR_RESET      = 16'h0000;
    localparam logic [PTR_W-1:0] RES_ENTRY_STEP = 16'h0008;
    localparam logic [15:0]      TALLY_MAX      = 16'hFFFF;
    localparam logic [15:0]      TALLY_ZERO     = 16'h0000;
    localparam logic [31:0]      TIMER_ZERO     = 32'h0000_0000;
    localparam logic [31:0]      TIMER_ONES     = 32'hFFFF_FFFF;

    typedef logic [2:0][15:0] nes_tally_t;

    typedef struct packed {
        logic byteCountMismatch;
        logic excessCollisions;
        logic txUnderrunErr;
        logic excessDeferral;
    } nes_tx_cause_t;

    typedef struct packed {
        logic          txDone;
        nes_tx_cause_t cause;
    } nes_tx_evt_t;

    typedef struct packed {
        logic listEndSeen;
        logic bufferDone;
        logic areaEndHit;
        logic fetchDone;
        logic fifoFull;
        logic busGranted;
    } nes_rx_evt_t;

    typedef struct packed {
        logic fetchReq;
        logic frameAbort;
        logic rxEnable;
    } nes_rx_ctl_t;

    typedef struct packed {
        logic [8:0]       mask;
        logic [PTR_W-1:0] wptr;
        logic [PTR_W-1:0] rptr;
        logic [31:0]      prdata;
        nes_tx_cause_t    txStatus;
        logic [31:0]      timerPrev;
        nes_tally_t       tallyPrev;
        logic             halted;
        logic             fetchBusy;
        logic             resumeFetch;
        logic             fetchReq;
        logic             frameAbort;
        logic             irq;
    } nes_state_t;

    localparam nes_state_t STATE_RESET = '{
        mask:        MASK_RESET,
        wptr:        PTR_RESET,
        rptr:        PTR_RESET,
        prdata:      32'h0000_0000,
        txStatus:    4'h0,
        // ones, not zero: a timer parked at ones must not look like a wrap after reset
        timerPrev:   TIMER_ONES,
        tallyPrev:   48'h0000_0000_0000,
        halted:      1'b0,
        fetchBusy:   1'b0,
        resumeFetch: 1'b0,
        fetchReq:    1'b0,
        frameAbort:  1'b0,
        irq:         1'b0
    };

    typedef struct packed {
        logic [NUM_FLAGS-1:0] flags;
    } nes_bank_t;
endpackage : nes_pkg

// File: nes_sticky_bank.sv
// nes_sticky_bank: sticky event flags, write-one-to-clear
`timescale 1ns/10ps
module nes_sticky_bank #(
    parameter int unsigned WIDTH = nes_pkg::NUM_FLAGS
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             reset,
    // set events and clear strobes
    input  wire logic [WIDTH-1:0] setEv,
    input  wire logic [WIDTH-1:0] clrMask,
    // flag state
    output logic      [WIDTH-1:0] flags
);
    import nes_pkg::*;

    nes_bank_t        st;
    nes_bank_t        st_nxt;
    logic [WIDTH-1:0] flagNext;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            // a set in the clearing cycle survives
            assign flagNext[i] = setEv[i] | (st.flags[i] & ~clrMask[i]);

            property p_set_wins;
                @(posedge clock) disable iff (reset)
                setEv[i] && clrMask[i] |=> flags[i];
            endproperty
            a_p_set_wins: assert property (p_set_wins)
                else $error("flag lost when set and clear coincide");
        end
    endgenerate

    always_comb begin
        st_nxt       = st;
        st_nxt.flags = flagNext;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            st.flags <= FLAGS_RESET;
        end else begin
            st <= st_nxt;
        end
    end

    assign flags = st.flags;
endmodule : nes_sticky_bank

// File: nes_dma_model.sv
// nes_dma_model: receive dma stand-in that answers resource fetches
`timescale 1ns/10ps
module nes_dma_model (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       reset,
    // fetch handshake
    input  wire logic       fetchReq,
    input  wire logic [3:0] latency,
    output logic            fetchDone
);
    logic [3:0] cnt_r;
    logic       busy_r;

    // one fetch at a time; latency lets the bench play a fast or a slow memory
    always_ff @(posedge clock) begin
        if (reset) begin
            busy_r    <= 1'b0;
            cnt_r     <= 4'h0;
            fetchDone <= 1'b0;
        end else begin
            fetchDone <= 1'b0;
            if (fetchReq) begin
                busy_r <= 1'b1;
                cnt_r  <= latency;
            end else if (busy_r) begin
                if (cnt_r == 4'h0) begin
                    busy_r    <= 1'b0;
                    fetchDone <= 1'b1;
                end else begin
                    cnt_r <= cnt_r - 4'h1;
                end
            end
        end
    end
endmodule : nes_dma_model

// File: tb_nes_event_status.sv
// tb_nes_event_status: self-checking bench for the low event status block
`timescale 1ns/10ps
module tb_nes_event_status;
    import nes_pkg::*;
    logic          clock = 1'b0;
    logic          reset = 1'b1;
    logic          psel = 1'b0;
    logic          penable = 1'b0;
    logic          pwrite = 1'b0;
    logic [7:0]    paddr = 8'h00;
    logic [31:0]   pwdata = 32'h0;
    logic [31:0]   prdata;
    logic [31:0]   rdat;
    logic          pready;
    logic          pslverr;
    logic          rerr;
    logic          irq;
    logic          dmaDone;
    logic [3:0]    latency = 4'h0;
    logic [31:0]   timerValue = 32'h0000_0005;
    nes_tally_t    tallyValue = '0;
    nes_tx_evt_t   txEvt = '0;
    nes_rx_evt_t   rxIn = '0;
    nes_rx_evt_t   rxEvt;
    nes_rx_ctl_t   rxCtl;
    nes_tx_cause_t txDescStatus;
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int reqCnt = 0;
    int abortCnt = 0;
    int doneCnt = 0;

    assign rxEvt = rxIn | nes_rx_evt_t'({3'b000, dmaDone, 2'b00});
    always #25 clock = ~clock;

    nes_event_status nes_event_status_i (.clock(clock), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .txEvt(txEvt), .timerValue(timerValue),
        .tallyValue(tallyValue), .rxEvt(rxEvt), .rxCtl(rxCtl), .txDescStatus(txDescStatus),
        .irq(irq));
    nes_dma_model nes_dma_model_i (.clock(clock), .reset(reset), .fetchReq(rxCtl.fetchReq),
        .latency(latency), .fetchDone(dmaDone));

    task automatic end_sim;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim

    // pulse counters, plus a ceiling well above the few hundred cycles needed
    always @(posedge clock) begin
        cycles++;
        if (!reset && rxCtl.fetchReq === 1'b1) reqCnt++;
        if (!reset && rxCtl.frameAbort === 1'b1) abortCnt++;
        if (!reset && dmaDone === 1'b1) doneCnt++;
        if (cycles == 8000) begin
            errors++;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask : rdchk

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick

    // status must read exactly exp, then everything is cleared
    task automatic stat_clr(input logic [31:0] exp);
        rdchk(OFS_STATUS, exp);
        apb(1'b1, OFS_STATUS, 32'h0000_01FF);
    endtask : stat_clr

    task automatic rx_pulse(input int b);
        @(posedge clock);
        rxIn <= nes_rx_evt_t'(6'h01 << b);
        @(posedge clock);
        rxIn <= '0;
    endtask : rx_pulse

    task automatic tx_pulse(input logic [3:0] c);
        @(posedge clock);
        txEvt <= {1'b1, c};
        @(posedge clock);
        txEvt <= '0;
    endtask : tx_pulse

    task automatic wait_done(input int n);
        int k;
        k = 0;
        while (doneCnt < n && k < 100) begin
            @(posedge clock);
            k++;
        end
        tick(3);
    endtask : wait_done

    task automatic t_reset;
        rdchk(OFS_STATUS, 32'h0);
        rdchk(OFS_MASK, 32'h0);
        rdchk(OFS_TXST, 32'h0);
        chk(rxCtl.rxEnable, 1'b1);
        apb(1'b0, 8'h22, 32'h0);
        chk(rerr, 1'b1);
        chk(rdat, 32'h0);
    endtask : t_reset

    task automatic t_tx;
        for (int c = 0; c < 4; c++) begin
            tx_pulse(4'h8 >> c);
            tick(2);
            rdchk(OFS_STATUS, 32'h100);
            rdchk(OFS_TXST, 32'h8 >> c);
            chk(txDescStatus, 4'h8 >> c);
            apb(1'b1, OFS_STATUS, 32'h0);
            rdchk(OFS_STATUS, 32'h100);
            apb(1'b1, OFS_STATUS, 32'h100);
            rdchk(OFS_STATUS, 32'h0);
        end
    endtask : t_tx

    task automatic t_sources;
        timerValue <= 32'h0000_0002;
        tick(1);
        timerValue <= 32'hFFFF_FFFF;
        tick(2);
        stat_clr(32'h0);
        timerValue <= 32'h0000_0000;
        tick(1);
        timerValue <= 32'hFFFF_FFFF;
        tick(2);
        stat_clr(32'h080);
        for (int i = 0; i < 3; i++) begin
            tallyValue[i] <= 16'hFFFF;
            tick(1);
            tallyValue[i] <= 16'h0000;
            tick(2);
            stat_clr(32'h1 << (i + 1));
        end
        rx_pulse(5);
        tick(2);
        stat_clr(32'h040);
        rxIn <= 6'h03;
        tick(3);
        stat_clr(32'h0);
        rxIn <= 6'h02;
        tick(2);
        rxIn <= '0;
        tick(1);
        stat_clr(32'h001);
    endtask : t_sources

    task automatic t_irq;
        tx_pulse(4'h1);
        tick(3);
        chk(irq, 1'b0);
        apb(1'b1, OFS_MASK, 32'h080);
        tick(2);
        chk(irq, 1'b0);
        apb(1'b1, OFS_MASK, 32'h100);
        tick(2);
        chk(irq, 1'b1);
        apb(1'b1, OFS_STATUS, 32'h100);
        tick(2);
        chk(irq, 1'b0);
    endtask : t_irq

    // the clearing write and a new transmit error land on the same edge
    task automatic t_race;
        tx_pulse(4'h2);
        tick(2);
        fork
            apb(1'b1, OFS_STATUS, 32'h100);
            begin
                tick(2);
                txEvt <= {1'b1, 4'h2};
                tick(1);
                txEvt <= '0;
            end
        join
        tick(2);
        stat_clr(32'h100);
    endtask : t_race

    task automatic t_resource;
        apb(1'b1, OFS_WPTR, 32'h10);
        rx_pulse(3);
        wait_done(1);
        chk(abortCnt, 1);
        chk(reqCnt, 1);
        rdchk(OFS_STATUS, 32'h010);
        latency <= 4'h6;
        rx_pulse(4);
        wait_done(2);
        rdchk(OFS_STATUS, 32'h030);
        rdchk(OFS_RPTR, 32'h10);
        chk(rxCtl.rxEnable, 1'b1);
        apb(1'b1, OFS_STATUS, 32'h010);
        rx_pulse(4);
        tick(3);
        chk(rxCtl.rxEnable, 1'b0);
        chk(reqCnt, 2);
        rdchk(OFS_RXCTL, 32'h1);
        apb(1'b1, OFS_WPTR, 32'h18);
        tick(3);
        chk(rxCtl.rxEnable, 1'b0);
        apb(1'b1, OFS_STATUS, 32'h020);
        wait_done(3);
        chk(reqCnt, 3);
        chk(rxCtl.rxEnable, 1'b1);
        rdchk(OFS_RPTR, 32'h18);
        stat_clr(32'h020);
        apb(1'b1, OFS_RXCTL, 32'h1);
        wait_done(4);
        chk(reqCnt, 4);
        rdchk(OFS_RPTR, 32'h20);
    endtask : t_resource

    // a mid-run hardware reset wipes flags, mask and pointers
    task automatic t_hw_reset;
        tx_pulse(4'h4);
        tick(2);
        chk(irq, 1'b1);
        reset <= 1'b1;
        tick(2);
        reset <= 1'b0;
        rdchk(OFS_STATUS, 32'h0);
        rdchk(OFS_RPTR, 32'h0);
        chk(irq, 1'b0);
    endtask : t_hw_reset

    initial begin
        tick(16);
        reset <= 1'b0;
        t_reset();
        t_tx();
        t_sources();
        t_irq();
        t_race();
        t_resource();
        t_hw_reset();
        end_sim();
    end
endmodule : tb_nes_event_status
